/* File: include/spm_defines.vh */
`ifndef SPM_DEFINES_VH
`define SPM_DEFINES_VH
// Map array shape
`define SPM_MAP_COUNT 16
`define SPM_MAP_REGS 64
`define SPM_ENTRY_W 16
// Map entry fields, bit 0 is the msb in the manual numbering
`define SPM_ME_PAGE_HI 15
`define SPM_ME_PAGE_LO 3
`define SPM_ME_REF 2
`define SPM_ME_DIRTY 1
`define SPM_ME_ABSENT 0
// Fixed map numbers
`define SPM_MAP_USER_DATA 4'h0
`define SPM_MAP_SYS_DATA 4'h1
`define SPM_MAP_USER_CODE 4'h2
`define SPM_MAP_SYS_CODE 4'h3
`define SPM_MAP_LIB_CODE 4'h4
`define SPM_MAP_SYS_CODE_EXT 4'h5
`define SPM_MAP_BUF_FIRST 4'h6
`define SPM_MAP_BUF_LAST 4'hd
`define SPM_MAP_SPECIAL 4'he
`define SPM_MAP_XCACHE 4'hf
// Map 14 partitions
`define SPM_M14_SEGTAB_FIRST 6'h1c
`define SPM_M14_SEGTAB_LAST 6'h2b
`define SPM_M14_FRAMESEG_FIRST 6'h2c
`define SPM_M14_FRAMEPG_FIRST 6'h34
`define SPM_M14_BASE_FIRST 6'h3c
`define SPM_M14_LIMIT_FIRST 6'h3e
// Segment table entry
`define SPM_STE_UNMAPPED 5'h1f
// Cache identifier empty marker
`define SPM_CID_EMPTY 16'hffff
// Fixed system data locations
`define SPM_SYS_CURPROC 16'h0003
`define SPM_SYS_USEC_FIRST 16'h0043
`define SPM_SYS_USEC_LAST 16'h0046
`define SPM_SYS_VEC_FIRST 16'h0280
`define SPM_SYS_VEC_LAST 16'h02df
// Power fail save page
`define SPM_PF_SAVE_PAGE 13'h0002
// Register port offsets
`define SPM_REG_MAPADDR 4'h0
`define SPM_REG_MAPDATA 4'h1
`define SPM_REG_STATUS 4'h2
`define SPM_REG_STE_HI 4'h3
`define SPM_REG_STE_LO 4'h4
`define SPM_REG_STE_DEC 4'h5
`define SPM_REG_PFSAVE 4'h6
`endif

/* File: design/spm_map_ram.v */
`timescale 1ns/1ps
// Map register array, one write port shared with the update step, one registered read port
module spm_map_ram (
    input wire sys_clk, // Clock
    input wire wrEn, // Write enable
    input wire [9:0] wrAddr, // Write index
    input wire [15:0] wrData, // Write data
    input wire [9:0] rdAddr, // Read index
    output reg [15:0] rdData_ff // Registered read data
);
    // Storage of 16 maps of 64 entries
    reg [15:0] mem [0:1023];

    // Write then registered read
    always @(posedge sys_clk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData_ff <= mem[rdAddr];
    end
endmodule

/* File: design/spm_xaddr_split.v */
`timescale 1ns/1ps
// Extended address field split, registered
module spm_xaddr_split (
    input wire sys_clk, // Clock
    input wire sys_rst, // Sync reset
    input wire [31:0] xAddr, // Extended address, bit 31 is manual bit 0
    output reg absMode_ff, // Absolute mode
    output reg badZero_ff, // Bit that must be zero is set
    output reg [12:0] segNum_ff, // Segment
    output reg [5:0] pageNum_ff, // Logical page
    output reg [9:0] wordNum_ff // Word in page
);
    // Field capture
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            absMode_ff <= 1'b0;
            badZero_ff <= 1'b0;
            segNum_ff <= 13'h0000;
            pageNum_ff <= 6'h00;
            wordNum_ff <= 10'h000;
        end else begin
            absMode_ff <= xAddr[31];
            badZero_ff <= xAddr[30];
            segNum_ff <= xAddr[29:17];
            pageNum_ff <= xAddr[16:11];
            wordNum_ff <= xAddr[10:1];
        end
    end
endmodule

/* File: design/spm_translate.v */
`timescale 1ns/1ps
`include "spm_defines.vh"
module spm_translate (
    input wire sys_clk, // Clock 200 MHz
    input wire sys_rst, // Sync reset, active high
    input wire [3:0] regAddr, // Register port address
    input wire [31:0] regWrData, // Register write data
    input wire regWr, // Register write strobe
    input wire regRd, // Register read strobe
    output reg [31:0] regRdData_ff, // Read data, cycle after strobe
    input wire reqValid, // Translation request pulse
    input wire [1:0] reqKind, // 0 data, 1 code, 2 extended
    input wire reqWrite, // Request is a write
    input wire reqSysGlobal, // System-global-relative data
    input wire reqLoadUserCode, // Load user code word
    input wire [15:0] reqLogAddr, // 16-bit word address
    input wire [31:0] reqXAddr, // 32-bit extended address
    input wire dataSpaceSelect, // Data space select bit
    input wire kernelModeFlag, // Kernel mode flag
    input wire systemCodeSelect, // System code select bit
    input wire libraryCodeSelect, // Library code select bit
    output reg rspValid_ff, // Result pulse
    output reg [22:0] rspPhysAddr_ff, // Physical word address
    output reg rspPageFault_ff, // Absent page fault
    output reg rspProtFault_ff, // Access not allowed
    output reg rspCacheHit_ff, // Extended cache hit
    output reg rspCacheMiss_ff // Extended cache miss or empty
);
    // Request kinds
    localparam KIND_DATA = 2'h0;
    localparam KIND_CODE = 2'h1;
    localparam KIND_EXT = 2'h2;
    // Pipeline states
    localparam ST_IDLE = 2'h0;
    localparam ST_LOOK = 2'h1;
    localparam ST_ENTRY = 2'h2;
    localparam ST_UPD = 2'h3;

    // Map code select, used by normal code fetch
    function [3:0] codeMap;
        input lib;
        input sys;
        begin
            case ({lib, sys})
                2'b00: codeMap = `SPM_MAP_USER_CODE;
                2'b01: codeMap = `SPM_MAP_SYS_CODE;
                2'b10: codeMap = `SPM_MAP_LIB_CODE;
                default: codeMap = `SPM_MAP_SYS_CODE_EXT;
            endcase
        end
    endfunction

    reg [1:0] state_ff; // Pipeline state
    reg [1:0] nxt_state;
    reg [3:0] mapSel_ff; // Selected map
    reg [5:0] entSel_ff; // Selected entry
    reg [9:0] wordSel_ff; // Word in page
    reg isWrite_ff; // Pending write
    reg isExt_ff; // Pending extended lookup
    reg [13:0] tagWant_ff; // Expected identifier
    reg [9:0] mapIndex_ff; // Software map pointer
    reg [31:0] steWord_ff; // Segment table entry for decode
    reg [12:0] pfSavePage_ff; // Power fail save page
    reg [7:0] faultCount_ff; // Page faults seen
    reg [9:0] ramRdAddr; // RAM read index
    reg ramWe; // RAM write enable
    reg [9:0] ramWa; // RAM write index
    reg [15:0] ramWd; // RAM write data
    wire [15:0] ramRd; // RAM read data
    wire xAbs; // Extended fields
    wire xBad;
    wire [12:0] xSeg;
    wire [5:0] xPage;
    wire [9:0] xWord;
    reg [3:0] dataMap; // Data map choice
    reg dataOk; // Data access allowed
    reg [15:0] entryHold_ff; // Fetched map entry
    reg [15:0] updEntry; // Entry seen by the update step

    spm_map_ram uMapRam (
        .sys_clk(sys_clk),
        .wrEn(ramWe),
        .wrAddr(ramWa),
        .wrData(ramWd),
        .rdAddr(ramRdAddr),
        .rdData_ff(ramRd)
    );

    spm_xaddr_split uSplit (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .xAddr(reqXAddr),
        .absMode_ff(xAbs),
        .badZero_ff(xBad),
        .segNum_ff(xSeg),
        .pageNum_ff(xPage),
        .wordNum_ff(xWord)
    );

    // Data map selection and access permission
    always @* begin
        dataMap = `SPM_MAP_USER_DATA;
        dataOk = 1'b1;
        if (reqSysGlobal || dataSpaceSelect) begin
            dataMap = `SPM_MAP_SYS_DATA;
            dataOk = dataSpaceSelect | kernelModeFlag;
        end
    end

    // Entry used by the update step; an extended hit takes the cached half straight off the read port
    always @* begin
        updEntry = isExt_ff ? ramRd : entryHold_ff;
        if (!isExt_ff && mapSel_ff == `SPM_MAP_SYS_DATA && entSel_ff[5:1] == 5'h00) begin
            updEntry = {12'h000, entSel_ff[0], entryHold_ff[`SPM_ME_REF:`SPM_ME_DIRTY], 1'b0};
        end
    end

    // RAM port steering: lookup reads, ref/dirty update, software writes
    always @* begin
        ramRdAddr = {mapSel_ff, entSel_ff};
        ramWe = 1'b0;
        ramWa = mapIndex_ff;
        ramWd = regWrData[15:0];
        if (state_ff == ST_IDLE && reqValid) begin
            if (reqKind == KIND_CODE) begin
                if (reqLoadUserCode) begin
                    ramRdAddr = {`SPM_MAP_USER_CODE, reqLogAddr[15:10]};
                end else begin
                    ramRdAddr = {codeMap(libraryCodeSelect, systemCodeSelect), reqLogAddr[15:10]};
                end
            end else begin
                ramRdAddr = {dataMap, reqLogAddr[15:10]};
            end
        end else if (state_ff == ST_LOOK && isExt_ff) begin
            ramRdAddr = {`SPM_MAP_XCACHE, 1'b1, xPage[4:0]};
        end else if (state_ff == ST_ENTRY && isExt_ff) begin
            ramRdAddr = {`SPM_MAP_XCACHE, 1'b0, entSel_ff[4:0]};
        end
        if (state_ff == ST_UPD) begin
            // set reference, and dirty on writes only
            // Refused accesses leave the usage bits alone
            ramWe = ~updEntry[`SPM_ME_ABSENT] & ~rspProtFault_ff;
            ramWa = {mapSel_ff, entSel_ff};
            ramWd = updEntry | 16'h0004 | {14'h0000, isWrite_ff, 1'b0};
        end else if (regWr && regAddr == `SPM_REG_MAPDATA) begin
            ramWe = 1'b1;
        end
    end

    // State sequencing
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (reqValid) begin
                    nxt_state = (reqKind == KIND_EXT) ? ST_LOOK : ST_ENTRY;
                end
            end
            ST_LOOK: nxt_state = ST_ENTRY;
            ST_ENTRY: nxt_state = ST_UPD;
            default: nxt_state = ST_IDLE;
        endcase
    end

    // Translation pipeline
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            state_ff <= ST_IDLE;
            mapSel_ff <= 4'h0;
            entSel_ff <= 6'h00;
            wordSel_ff <= 10'h000;
            isWrite_ff <= 1'b0;
            isExt_ff <= 1'b0;
            tagWant_ff <= 14'h0000;
            entryHold_ff <= 16'h0000;
            rspValid_ff <= 1'b0;
            rspPhysAddr_ff <= 23'h00_0000;
            rspPageFault_ff <= 1'b0;
            rspProtFault_ff <= 1'b0;
            rspCacheHit_ff <= 1'b0;
            rspCacheMiss_ff <= 1'b0;
            faultCount_ff <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            rspValid_ff <= 1'b0;
            rspCacheHit_ff <= 1'b0;
            rspCacheMiss_ff <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    if (reqValid) begin
                        mapSel_ff <= ramRdAddr[9:6];
                        entSel_ff <= ramRdAddr[5:0];
                        wordSel_ff <= reqLogAddr[9:0];
                        isWrite_ff <= reqWrite;
                        isExt_ff <= (reqKind == KIND_EXT);
                        rspProtFault_ff <= (reqKind == KIND_DATA) && !dataOk;
                        rspPageFault_ff <= 1'b0;
                    end
                end
                ST_LOOK: begin
                    // Extended fields now stable
                    mapSel_ff <= `SPM_MAP_XCACHE;
                    entSel_ff <= {1'b0, xPage[4:0]};
                    wordSel_ff <= xWord;
                    tagWant_ff <= {xSeg, xPage[5]};
                    rspProtFault_ff <= xBad;
                end
                ST_ENTRY: begin
                    if (isExt_ff) begin
                        if (ramRd == `SPM_CID_EMPTY || ramRd[13:0] != tagWant_ff) begin
                            isExt_ff <= 1'b0;
                            rspCacheMiss_ff <= 1'b1;
                            rspValid_ff <= 1'b1;
                            state_ff <= ST_IDLE;
                        end
                    end else begin
                        entryHold_ff <= ramRd;
                    end
                end
                default: begin
                    if (isExt_ff) begin
                        rspCacheHit_ff <= 1'b1;
                    end
                    rspValid_ff <= 1'b1;
                    rspPageFault_ff <= updEntry[`SPM_ME_ABSENT];
                    if (updEntry[`SPM_ME_ABSENT]) begin
                        faultCount_ff <= faultCount_ff + 8'h01;
                    end
                    rspPhysAddr_ff <= {updEntry[`SPM_ME_PAGE_HI:`SPM_ME_PAGE_LO], wordSel_ff};
                end
            endcase
            // Extended hit: entry half arrives during update step
            if (state_ff == ST_ENTRY && isExt_ff) begin
                entryHold_ff <= 16'h0000;
            end
        end
    end

    // buffer maps general
    // Maps 6 to 13 and 14 are plain storage here; no special routing.
    // map 14 partition
    // Partition indices live in the header for microcode use.

    // Software map pointer, segment entry and save page registers
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            mapIndex_ff <= 10'h000;
            steWord_ff <= 32'h0000_0000;
            pfSavePage_ff <= `SPM_PF_SAVE_PAGE;
        end else if (regWr) begin
            if (regAddr == `SPM_REG_MAPADDR) begin
                mapIndex_ff <= regWrData[9:0];
            end else if (regAddr == `SPM_REG_MAPDATA) begin
                mapIndex_ff <= mapIndex_ff + 10'h001;
            end else if (regAddr == `SPM_REG_STE_HI) begin
                steWord_ff[31:16] <= regWrData[15:0];
            end else if (regAddr == `SPM_REG_STE_LO) begin
                steWord_ff[15:0] <= regWrData[15:0];
            end
        end
    end

    // Segment table entry decode, msb is field bit 0
    reg [31:0] steDecoded;
    always @* begin
        if (steWord_ff[31:27] != `SPM_STE_UNMAPPED) begin
            steDecoded = {1'b1, 26'h000_0000, steWord_ff[31:27]};
        end else begin
            steDecoded = {1'b0, steWord_ff[26:23], steWord_ff[22:16], steWord_ff[15:10], steWord_ff[9:0],
                4'h0};
        end
    end

    // Register reads, data in the following cycle
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            regRdData_ff <= 32'h0000_0000;
        end else if (regRd) begin
            if (regAddr == `SPM_REG_MAPADDR) begin
                regRdData_ff <= {22'h00_0000, mapIndex_ff};
            end else if (regAddr == `SPM_REG_STATUS) begin
                regRdData_ff <= {20'h0_0000, faultCount_ff, 2'h0, state_ff};
            end else if (regAddr == `SPM_REG_STE_HI) begin
                regRdData_ff <= {16'h0000, steWord_ff[31:16]};
            end else if (regAddr == `SPM_REG_STE_LO) begin
                regRdData_ff <= {16'h0000, steWord_ff[15:0]};
            end else if (regAddr == `SPM_REG_STE_DEC) begin
                regRdData_ff <= steDecoded;
            end else if (regAddr == `SPM_REG_PFSAVE) begin
                regRdData_ff <= {19'h0_0000, pfSavePage_ff};
            end else begin
                regRdData_ff <= 32'h0000_0000;
            end
        end
    end

    // fixed tables by software
    // System data pages 0 and 1 are forced in the update entry above
endmodule

/* File: test/spm_translate_monitor.sv */
`timescale 1ns/1ps
// Port checks on the translation unit
module spm_translate_monitor (
    input wire sys_clk, // Clock
    input wire sys_rst, // Sync reset
    input wire [3:0] regAddr, // Register index
    input wire regRd, // Read strobe
    input wire [31:0] regRdData_ff, // Read data
    input wire reqValid, // Request pulse
    input wire [1:0] reqKind, // Request kind
    input wire reqSysGlobal, // Global-relative data
    input wire [15:0] reqLogAddr, // Word address
    input wire dataSpaceSelect, // Data space select
    input wire kernelModeFlag, // Kernel flag
    input wire rspValid_ff, // Result pulse
    input wire [22:0] rspPhysAddr_ff, // Physical address
    input wire rspPageFault_ff, // Page fault
    input wire rspProtFault_ff, // Protection fault
    input wire rspCacheHit_ff, // Cache hit
    input wire rspCacheMiss_ff // Cache miss
);
    // All checks on the one clock
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    property p_lat;
        reqValid && reqKind != 2'd2 |-> ##3 rspValid_ff;
    endproperty
    a_lat: assert property (p_lat) else $error("plain result late");
    property p_xlat;
        reqValid && reqKind == 2'd2 |-> ##[3:4] rspValid_ff;
    endproperty
    a_xlat: assert property (p_xlat) else $error("extended result late");
    property p_once;
        rspValid_ff |=> !rspValid_ff;
    endproperty
    a_once: assert property (p_once) else $error("result not a pulse");
    property p_word;
        reqValid && reqKind != 2'd2 |-> ##3 rspPhysAddr_ff[9:0] == $past(reqLogAddr[9:0], 3);
    endproperty
    a_word: assert property (p_word) else $error("word offset lost");
    property p_prot;
        reqValid && reqKind == 2'd0 && reqSysGlobal && !dataSpaceSelect && !kernelModeFlag |-> ##3 rspProtFault_ff;
    endproperty
    a_prot: assert property (p_prot) else $error("system data not refused");
    property p_noprot;
        reqValid && reqKind == 2'd0 && !reqSysGlobal |-> ##3 !rspProtFault_ff;
    endproperty
    a_noprot: assert property (p_noprot) else $error("data access refused");
    property p_hold;
        !rspValid_ff && !$past(reqValid) |-> $stable(rspPageFault_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("fault moved between results");
    property p_flag;
        rspCacheHit_ff || rspCacheMiss_ff |-> rspValid_ff && !(rspCacheHit_ff && rspCacheMiss_ff);
    endproperty
    a_flag: assert property (p_flag) else $error("hit and miss flags bad");
    property p_save;
        regRd && regAddr == 4'h6 |=> regRdData_ff == 32'h0000_0002;
    endproperty
    a_save: assert property (p_save) else $error("save page wrong");
    // Main scenarios seen
    c_hit: cover property (rspCacheHit_ff);
    c_miss: cover property (rspCacheMiss_ff);
    c_page: cover property (rspValid_ff && rspPageFault_ff);
    c_prot: cover property (rspValid_ff && rspProtFault_ff);
endmodule
bind spm_translate spm_translate_monitor i_spm_translate_monitor (.sys_clk, .sys_rst, .regAddr, .regRd,
    .regRdData_ff, .reqValid, .reqKind, .reqSysGlobal, .reqLogAddr, .dataSpaceSelect, .kernelModeFlag,
    .rspValid_ff, .rspPhysAddr_ff, .rspPageFault_ff, .rspProtFault_ff, .rspCacheHit_ff, .rspCacheMiss_ff);

/* File: test/spm_cpu_model.sv */
`timescale 1ns/1ps
// Instruction unit model, one reference at a time
module spm_cpu_model (
    input wire sys_clk, // Clock
    input wire rspValid_ff, // Result pulse
    output reg reqValid, // Request pulse
    output reg [1:0] reqKind, // Request kind
    output reg reqWrite, // Write reference
    output reg reqSysGlobal, // Global-relative data
    output reg reqLoadUserCode, // User code load
    output reg [15:0] reqLogAddr, // Word address
    output reg [31:0] reqXAddr, // Extended address
    output reg dataSpaceSelect, // Data space select
    output reg kernelModeFlag, // Kernel flag
    output reg systemCodeSelect, // System code select
    output reg libraryCodeSelect // Library code select
);
    // Quiet at time zero
    initial begin
        {reqValid, reqKind, reqWrite, reqSysGlobal, reqLoadUserCode} = 5'h00;
        {reqLogAddr, reqXAddr} = 48'h0000_0000_0000;
        {dataSpaceSelect, kernelModeFlag, systemCodeSelect, libraryCodeSelect} = 4'h0;
    end
    // Issue a reference, wait for its result; lat counts edges from acceptance
    task automatic send(input [1:0] k, input w, input sg, input luc, input [3:0] env,
        input [15:0] la, input [31:0] xa, output int lat);
        begin
            @(posedge sys_clk);
            reqValid <= 1'b1;
            reqKind <= k;
            reqWrite <= w;
            reqSysGlobal <= sg;
            reqLoadUserCode <= luc;
            reqLogAddr <= la;
            reqXAddr <= xa;
            {dataSpaceSelect, kernelModeFlag, systemCodeSelect, libraryCodeSelect} <= env;
            @(posedge sys_clk);
            reqValid <= 1'b0;
            // Address held one more cycle, then scrambled so stale values never pass
            @(posedge sys_clk);
            reqLogAddr <= ~reqLogAddr;
            reqXAddr <= ~reqXAddr;
            lat = 2;
            do begin
                @(posedge sys_clk);
                lat = lat + 1;
                #1;
            end while (!rspValid_ff && lat < 12);
        end
    endtask
endmodule

/* File: test/spm_translate_test.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin errorCnt++; $display("BAD %0t got %h exp %h", $time, (a), (e)); end end
// Self-checking bench for the translation unit
module spm_translate_test;
    reg sys_clk = 1'b0; // Clock
    reg sys_rst = 1'b1; // Reset
    reg [3:0] regAddr = 4'h0; // Register index
    reg [31:0] regWrData = 32'h0000_0000; // Write data
    reg regWr = 1'b0; // Write strobe
    reg regRd = 1'b0; // Read strobe
    wire [31:0] regRdData_ff; // Read data
    wire reqValid, reqWrite, reqSysGlobal, reqLoadUserCode; // Request controls
    wire [1:0] reqKind; // Request kind
    wire [15:0] reqLogAddr; // Word address
    wire [31:0] reqXAddr; // Extended address
    wire dataSpaceSelect, kernelModeFlag, systemCodeSelect, libraryCodeSelect; // State bits
    wire rspValid_ff, rspPageFault_ff, rspProtFault_ff, rspCacheHit_ff, rspCacheMiss_ff; // Result
    wire [22:0] rspPhysAddr_ff; // Physical address
    int errorCnt = 0; // Mismatches
    int checked = 0; // Compares
    int cycles = 0; // Run length
    int lat; // Result latency
    reg [31:0] rd; // Read value
    spm_translate i_spm_translate (.sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData_ff(regRdData_ff),
        .reqValid(reqValid), .reqKind(reqKind), .reqWrite(reqWrite), .reqSysGlobal(reqSysGlobal),
        .reqLoadUserCode(reqLoadUserCode), .reqLogAddr(reqLogAddr), .reqXAddr(reqXAddr),
        .dataSpaceSelect(dataSpaceSelect), .kernelModeFlag(kernelModeFlag),
        .systemCodeSelect(systemCodeSelect), .libraryCodeSelect(libraryCodeSelect),
        .rspValid_ff(rspValid_ff), .rspPhysAddr_ff(rspPhysAddr_ff), .rspPageFault_ff(rspPageFault_ff),
        .rspProtFault_ff(rspProtFault_ff), .rspCacheHit_ff(rspCacheHit_ff), .rspCacheMiss_ff(rspCacheMiss_ff));
    spm_cpu_model i_spm_cpu_model (.sys_clk(sys_clk), .rspValid_ff(rspValid_ff), .reqValid(reqValid),
        .reqKind(reqKind), .reqWrite(reqWrite), .reqSysGlobal(reqSysGlobal), .reqLoadUserCode(reqLoadUserCode),
        .reqLogAddr(reqLogAddr), .reqXAddr(reqXAddr), .dataSpaceSelect(dataSpaceSelect),
        .kernelModeFlag(kernelModeFlag), .systemCodeSelect(systemCodeSelect),
        .libraryCodeSelect(libraryCodeSelect));
    // 200 MHz clock
    always #2.5 sys_clk = ~sys_clk;
    // Cut a hang short
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errorCnt++;
            finishTest();
        end
    end
    // Verdict and end of run
    task finishTest;
        begin
            $display("compares %0d mismatches %0d", checked, errorCnt);
            if (errorCnt == 0 && checked > 0) begin
                $display("NO MISMATCHES");
            end else begin
                $display("MISMATCHES SEEN");
            end
            $finish;
        end
    endtask
    // One register write cycle
    task regWrite(input [3:0] a, input [31:0] d);
        begin
            @(posedge sys_clk);
            regAddr <= a;
            regWrData <= d;
            regWr <= 1'b1;
            @(posedge sys_clk);
            regWr <= 1'b0;
        end
    endtask
    // One register read, data taken in the cycle after the strobe
    task regRead(input [3:0] a, output [31:0] d);
        begin
            @(posedge sys_clk);
            regAddr <= a;
            regRd <= 1'b1;
            @(posedge sys_clk);
            regRd <= 1'b0;
            #1;
            d = regRdData_ff;
        end
    endtask
    // Load one map register through pointer and data
    task mapWrite(input [3:0] m, input [5:0] e, input [15:0] d);
        begin
            regWrite(4'h0, {22'h00_0000, m, e});
            regWrite(4'h1, {16'h0000, d});
        end
    endtask
    // Plain reference to page 5; map m expected, 15 means refused
    task xlat(input [1:0] k, input sg, input luc, input [3:0] env, input [3:0] m);
        begin
            i_spm_cpu_model.send(k, 1'b0, sg, luc, env, 16'h16ab, 32'h0000_0000, lat);
            `CHK(lat, 3)
            `CHK(rspProtFault_ff, m == 4'hf)
            if (m != 4'hf) `CHK(rspPhysAddr_ff, {13'h1230 + m, 10'h2ab})
        end
    endtask
    // Extended reference to segment 0abc, page pg
    task xsend(input [5:0] pg, input hit);
        begin
            i_spm_cpu_model.send(2'd2, 1'b0, 1'b0, 1'b0, 4'h0, 16'h0000, {2'b10, 13'h0abc, pg, 10'h155, 1'b0}, lat);
            `CHK({rspCacheHit_ff, rspCacheMiss_ff}, {hit, !hit})
            `CHK(lat, hit ? 4 : 3)
            if (hit) `CHK({rspPageFault_ff, rspPhysAddr_ff}, {1'b0, 13'h048d, 10'h155})
        end
    endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        #1;
        `CHK({rspValid_ff, rspPageFault_ff, rspProtFault_ff, rspCacheHit_ff, rspCacheMiss_ff}, 5'h00)
        regRead(4'h6, rd);
        `CHK(rd, 32'h0000_0002)
        regRead(4'hf, rd);
        `CHK(rd, 32'h0000_0000)
        regWrite(4'h3, 32'h0000_3923);
        regWrite(4'h4, 32'h0000_ffff);
        regRead(4'h5, rd);
        `CHK(rd, 32'h8000_0007)
        regWrite(4'h3, 32'h0000_fd45);
        regWrite(4'h4, 32'h0000_b555);
        regRead(4'h5, rd);
        `CHK(rd, {1'b0, 4'ha, 7'h45, 6'h2d, 10'h155, 4'h0})
        for (int i = 0; i < 6; i++) mapWrite(i[3:0], 6'd5, {13'h1230 + i[12:0], 3'b000});
        mapWrite(4'h0, 6'd6, 16'h0001);
        i_spm_cpu_model.send(2'd0, 1'b0, 1'b0, 1'b0, 4'h0, 16'h1800, 32'h0000_0000, lat);
        `CHK(rspPageFault_ff, 1'b1)
        regRead(4'h2, rd);
        `CHK(rd, 32'h0000_0010)
        i_spm_cpu_model.send(2'd0, 1'b1, 1'b0, 1'b0, 4'h0, 16'h16ab, 32'h0000_0000, lat);
        `CHK({rspPageFault_ff, rspPhysAddr_ff}, {1'b0, 13'h1230, 10'h2ab})
        xlat(2'd1, 1'b0, 1'b0, 4'b0000, 4'h2);
        xlat(2'd1, 1'b0, 1'b0, 4'b0010, 4'h3);
        xlat(2'd1, 1'b0, 1'b0, 4'b0001, 4'h4);
        xlat(2'd1, 1'b0, 1'b0, 4'b0011, 4'h5);
        xlat(2'd1, 1'b0, 1'b1, 4'b0011, 4'h2);
        xlat(2'd0, 1'b0, 1'b0, 4'b0100, 4'h0);
        xlat(2'd0, 1'b0, 1'b0, 4'b1000, 4'h1);
        xlat(2'd0, 1'b1, 1'b0, 4'b0100, 4'h1);
        xlat(2'd0, 1'b1, 1'b0, 4'b0000, 4'hf);
        mapWrite(4'h1, 6'd1, 16'h7771);
        i_spm_cpu_model.send(2'd0, 1'b0, 1'b0, 1'b0, 4'b1000, 16'h0403, 32'h0000_0000, lat);
        `CHK({rspPageFault_ff, rspPhysAddr_ff}, {1'b0, 13'h0001, 10'h003})
        mapWrite(4'hf, 6'd35, 16'hffff);
        mapWrite(4'hf, 6'd3, 16'h2468);
        xsend(6'd35, 1'b0);
        mapWrite(4'hf, 6'd35, {2'b00, 13'h0abc, 1'b1});
        xsend(6'd35, 1'b1);
        xsend(6'd3, 1'b0);
        finishTest();
    end
endmodule
